/* File: pkg/pspc_pkg.sv */
// Package of constants and types for the peripheral share policy control
package pspc_pkg;

	// Host count and data word widths
	localparam int NUM_HOSTS      = 4;
	localparam int HOST_W         = 2;
	localparam int KM_DATA_W      = 8;
	localparam int DEV_ID_W       = 16;

	// Self-test timing
	localparam int CLK_MHZ        = 50;
	localparam int SELFTEST_US    = 100;
	localparam int SELFTEST_CYC   = SELFTEST_US * CLK_MHZ;

	// Failure tone divider, half period in cycles
	localparam int TONE_HALF_CYC  = 12500;

	// Reset values
	localparam logic [1:0] HOST_RST = 2'h0;

	// Switch request source codes
	typedef enum logic [2:0] {
		pspc_src_button = 3'h0,
		pspc_src_remote = 3'h1,
		pspc_src_guard  = 3'h2,
		pspc_src_scan   = 3'h3,
		pspc_src_host   = 3'h4,
		pspc_src_hotkey = 3'h5
	} pspc_src_t;

	// Top-level state
	typedef enum logic [1:0] {
		pspc_st_test = 2'b00,
		pspc_st_edid = 2'b01,
		pspc_st_run  = 2'b10,
		pspc_st_fail = 2'b11
	} pspc_state_t;

	// Video side sub-channel bit positions
	localparam int SUB_EDID_D2C = 0;
	localparam int SUB_HPD_D2C  = 1;
	localparam int SUB_LINKTRN  = 2;
	localparam int SUB_CEC      = 3;
	localparam int SUB_EDID_C2D = 4;
	localparam int SUB_HDCP     = 5;
	localparam int SUB_MCCS     = 6;
	localparam int SUB_ARC      = 7;
	localparam int SUB_HEAC     = 8;
	localparam int SUB_HEC      = 9;
	localparam int SUB_W        = 10;

endpackage

/* File: hdl/pspc_skid.sv */
// Two-entry buffer with valid and ready on both sides and a flush
`timescale 1ns/10ps
module pspc_skid #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	initial begin
		if (WIDTH < 1) $error("WIDTH must be at least one");
	end

	logic [WIDTH-1:0] mem_r [2];
	logic             wp_r;
	logic             rp_r;
	logic [1:0]       cnt_r;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// Honest full and empty from the occupancy count
	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rp_r];

	// Flush drops held words, so no residue survives a purge
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else if (flush) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push) wp_r <= ~wp_r;
			if (pop) rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage is wiped on a flush so that no keystroke outlives a purge
	always_ff @(posedge clock) begin
		if (flush) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
		end else if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

endmodule // pspc_skid

/* File: hdl/pspc_ctrl.sv */
// Policy and switching control for a secure peripheral sharing switch
// Notes on behaviour
// [R1] Accept authorized peripherals at power-up and on hot attach.
// [R2] Keyboard and mouse end here; host sees only our emulated functions.
// [R3] Display identification is fetched once per power-on or reboot.
// [R4] A re-enumeration as an unauthorized device is rejected.
// [R5] No user data goes to non-volatile storage.
// [R6] DisplayPort: block CEC, EDID to display, HDCP and MCCS.
// [R7] DisplayPort: pass EDID and hot-plug to computer, and link training.
// [R8] HDMI: block ARC, CEC, EDID to display, HDCP, HEAC, HEC, MCCS.
// [R9] Keyboard and mouse data flow only from peripheral toward host.
// [R10] Video flows only from host input toward display output.
// [R11] Self-test failure enters a secure state that is held.
// [R12] Self-test runs only at start-up and checks user controls.
// [R13] Failure gives visual and audible warning, switching shut down.
// [R14] No internal memory reachable externally except display identification.
// [R15] Switch requests from scanning, hosts or hotkeys are refused.
// [R16] Selection changes only on buttons, wired remote or guarded devices.
// [R17] Keyboard and mouse always go to the same host.
// [R18] Each change of host purges buffered keyboard data.
// [R19] Tamper is detected and latched for later inspection.
// [R20] User data goes only to the host the user selected.
// [R21] Unauthorized peripherals are rejected at power-up and hot attach.
// [R22] A rejected peripheral raises an indication.
// [R23] In the failure state nothing passes in any direction.
// [R24] Until self-test passes, no host is selected or routed.
`timescale 1ns/10ps
module pspc_ctrl #(
	parameter int NUM_HOSTS    = pspc_pkg::NUM_HOSTS,
	parameter int SELFTEST_CYC = pspc_pkg::SELFTEST_CYC
) (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst_b,
	// Self-test of user controls
	input  wire logic                          ctl_test_ok,
	// Switch requests
	input  wire logic                          sw_req,
	input  wire logic [2:0]                    sw_src,
	input  wire logic [pspc_pkg::HOST_W-1:0]   sw_host,
	// Peripheral attach and identity
	input  wire logic                          per_enum,
	input  wire logic [pspc_pkg::DEV_ID_W-1:0] per_id,
	input  wire logic                          per_proto_ok,
	input  wire logic                          per_id_allowed,
	// Keyboard and mouse words from the peripheral terminator
	input  wire logic                          km_valid,
	output logic                               km_ready,
	input  wire logic [pspc_pkg::KM_DATA_W-1:0] km_data,
	// Emulated keyboard and mouse words toward the hosts
	output logic [NUM_HOSTS-1:0]               emu_valid,
	input  wire logic [NUM_HOSTS-1:0]          emu_ready,
	output logic [pspc_pkg::KM_DATA_W-1:0]     emu_data,
	// Display identification fetch
	output logic                               edid_fetch,
	input  wire logic                          edid_done,
	// Video path
	input  wire logic                          vid_is_hdmi,
	output logic [NUM_HOSTS-1:0]               vid_route,
	output logic [pspc_pkg::SUB_W-1:0]         sub_pass,
	// Tamper
	input  wire logic                          tamper_in,
	output logic                               tamper_seen,
	// Indications
	output logic [pspc_pkg::HOST_W-1:0]        sel_host,
	output logic                               sel_valid,
	output logic                               reject_led,
	output logic                               fail_led,
	output logic                               fail_tone
);

	initial begin
		if (NUM_HOSTS < 2 || NUM_HOSTS > 4)
			$error("NUM_HOSTS must lie between 2 and 4");
		if (SELFTEST_CYC < 1) $error("SELFTEST_CYC must be positive");
	end

	pspc_pkg::pspc_state_t             st_r, st_nxt;
	logic [31:0]                       tcnt_r;
	logic [15:0]                       tone_r;
	logic [pspc_pkg::HOST_W-1:0]       host_r;
	logic                              sel_valid_r;
	logic                              admit_r;
	logic                              reject_r;
	logic                              tamper_r;
	logic                              edid_req_r;
	logic                              edid_once_r;
	logic                              purge_r;
	logic                              fail_tone_r;
	logic                              fail_led_r;
	logic                              km_ready_w;
	logic [NUM_HOSTS-1:0]              emu_valid_r;
	logic [NUM_HOSTS-1:0]              vid_route_r;
	logic [pspc_pkg::SUB_W-1:0]        sub_r;
	logic [pspc_pkg::KM_DATA_W-1:0]    emu_data_r;
	logic                              buf_valid;
	logic [pspc_pkg::KM_DATA_W-1:0]    buf_data;

	// Switch source decode: only express user action may select
	wire src_user = (sw_src == 3'(pspc_pkg::pspc_src_button)) || // [R16]
		(sw_src == 3'(pspc_pkg::pspc_src_remote)) ||
		(sw_src == 3'(pspc_pkg::pspc_src_guard));
	wire host_ok  = (32'(sw_host) < NUM_HOSTS);
	wire running  = (st_r == pspc_pkg::pspc_st_run);
	wire sw_take  = running && sw_req && src_user && host_ok; // [R15]
	wire sw_chg   = sw_take && (!sel_valid_r || sw_host != host_r);

	// Admission: identity and protocol both checked on every enumeration
	wire per_good = per_id_allowed && per_proto_ok; // [R1] [R21]
	wire km_pass  = running && admit_r && sel_valid_r && !purge_r;

	// Output register slot is free when not holding an unaccepted word
	wire emu_hold = |(emu_valid_r & ~emu_ready);
	wire buf_pop  = km_pass && buf_valid && !emu_hold;

	// Input words only enter while a route exists; else they are refused
	pspc_skid #(
		.WIDTH (pspc_pkg::KM_DATA_W)
	) u_kbuf (
		.clock     (clock),
		.rst_b     (rst_b),
		.flush     (sw_chg || !running), // [R18]
		.in_valid  (km_valid && km_pass),
		.in_ready  (km_ready_w),
		.in_data   (km_data),
		.out_valid (buf_valid),
		.out_ready (buf_pop),
		.out_data  (buf_data)
	);
	assign km_ready = km_ready_w && km_pass; // [R9]

	// State sequencing: test, then fail, or one identification fetch and then run
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			pspc_pkg::pspc_st_test: begin
				if (tcnt_r >= 32'(SELFTEST_CYC - 1))
					st_nxt = ctl_test_ok ? pspc_pkg::pspc_st_edid
						: pspc_pkg::pspc_st_fail; // [R12] [R11]
			end
			pspc_pkg::pspc_st_edid: begin
				if (edid_done) st_nxt = pspc_pkg::pspc_st_run; // [R3]
			end
			pspc_pkg::pspc_st_run:  st_nxt = pspc_pkg::pspc_st_run;
			pspc_pkg::pspc_st_fail: st_nxt = pspc_pkg::pspc_st_fail; // [R11]
			default:                st_nxt = pspc_pkg::pspc_st_fail;
		endcase
	end

	// State and self-test counter; no path leads back into the test
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_r   <= pspc_pkg::pspc_st_test;
			tcnt_r <= 32'h0;
		end else begin
			st_r <= st_nxt;
			if (st_r == pspc_pkg::pspc_st_test) tcnt_r <= tcnt_r + 32'h1;
		end
	end

	// Display identification requested once; the once flag clears only on reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			edid_req_r  <= 1'b0;
			edid_once_r <= 1'b0;
		end else begin
			if (st_r == pspc_pkg::pspc_st_edid && !edid_once_r) begin
				edid_req_r  <= 1'b1; // [R3]
				edid_once_r <= 1'b1;
			end else begin
				edid_req_r <= 1'b0;
			end
		end
	end

	// Host selection; keyboard and mouse share the one register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			host_r      <= pspc_pkg::HOST_RST; // [R24]
			sel_valid_r <= 1'b0;
			purge_r     <= 1'b0;
		end else begin
			purge_r <= sw_chg; // [R18]
			if (!running) begin
				sel_valid_r <= 1'b0; // [R23]
			end else if (sw_take) begin
				host_r      <= sw_host; // [R16] [R17]
				sel_valid_r <= 1'b1;
			end
		end
	end

	// Peripheral admission, re-checked on each enumeration
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			admit_r  <= 1'b0;
			reject_r <= 1'b0;
		end else if (per_enum) begin
			admit_r  <= per_good; // [R4] [R21]
			reject_r <= !per_good; // [R22]
		end
	end

	// Tamper is sticky; only reset clears the volatile copy
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) tamper_r <= 1'b0;
		else if (tamper_in) tamper_r <= 1'b1; // [R19]
	end

	// Emulated output word, steered to the selected host only
	wire [NUM_HOSTS-1:0] host_onehot;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_HOSTS; gi++) begin : g_host
			assign host_onehot[gi] = sel_valid_r && running &&
				(32'(host_r) == gi); // [R20] [R17]
		end
	endgenerate

	// Words are re-sent by the emulator, never the raw peripheral link
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			emu_valid_r <= '0;
			emu_data_r  <= 8'h00;
		end else if (sw_chg || !running) begin
			emu_valid_r <= '0; // [R18] [R23]
			emu_data_r  <= '0; // Shared lines must not show the old word
		end else if (buf_pop) begin
			emu_valid_r <= host_onehot; // [R2] [R20]
			emu_data_r  <= buf_data;
		end else begin
			emu_valid_r <= emu_valid_r & ~emu_ready;
		end
	end

	// Sub-channel gates; outward only, blocked ones stay low
	wire [pspc_pkg::SUB_W-1:0] sub_nxt;
	assign sub_nxt[pspc_pkg::SUB_EDID_D2C] = running; // [R7] [R8] [R14]
	assign sub_nxt[pspc_pkg::SUB_HPD_D2C]  = running; // [R7] [R8]
	assign sub_nxt[pspc_pkg::SUB_LINKTRN]  = running && !vid_is_hdmi; // [R7]
	assign sub_nxt[pspc_pkg::SUB_CEC]      = 1'b0; // [R6] [R8]
	assign sub_nxt[pspc_pkg::SUB_EDID_C2D] = 1'b0; // [R6] [R8]
	assign sub_nxt[pspc_pkg::SUB_HDCP]     = 1'b0; // [R6] [R8]
	assign sub_nxt[pspc_pkg::SUB_MCCS]     = 1'b0; // [R6] [R8]
	assign sub_nxt[pspc_pkg::SUB_ARC]      = 1'b0; // [R8]
	assign sub_nxt[pspc_pkg::SUB_HEAC]     = 1'b0; // [R8]
	assign sub_nxt[pspc_pkg::SUB_HEC]      = 1'b0; // [R8]

	// Video routing registered from the same one-hot as keyboard
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			vid_route_r <= '0;
			sub_r       <= '0;
		end else begin
			vid_route_r <= host_onehot; // [R10] [R20]
			sub_r       <= sub_nxt;
		end
	end

	// Failure tone, a square wave while failed
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tone_r      <= 16'h0000;
			fail_tone_r <= 1'b0;
		end else if (st_r != pspc_pkg::pspc_st_fail) begin
			tone_r      <= 16'h0000;
			fail_tone_r <= 1'b0;
		end else if (32'(tone_r) >= pspc_pkg::TONE_HALF_CYC - 1) begin
			tone_r      <= 16'h0000;
			fail_tone_r <= ~fail_tone_r; // [R13]
		end else begin
			tone_r <= tone_r + 16'h0001;
		end
	end

	// Failure lamp taken from the next state, so it lights on entry
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) fail_led_r <= 1'b0;
		else fail_led_r <= (st_nxt == pspc_pkg::pspc_st_fail); // [R13]
	end

	// Registered outputs; nothing here writes non-volatile storage
	assign emu_valid   = emu_valid_r; // [R5]
	assign emu_data    = emu_data_r;
	assign vid_route   = vid_route_r;
	assign sub_pass    = sub_r;
	assign edid_fetch  = edid_req_r;
	assign tamper_seen = tamper_r;
	assign sel_host    = host_r;
	assign sel_valid   = sel_valid_r;
	assign reject_led  = reject_r;
	assign fail_led    = fail_led_r; // [R13]
	assign fail_tone   = fail_tone_r;

	// Assertions; each label line carries the rule that it guards
	a_fail_is_sticky: assert property ( // [R11]
		@(posedge clock) disable iff (!rst_b)
		st_r == pspc_pkg::pspc_st_fail |=> st_r == pspc_pkg::pspc_st_fail)
		else $error("left failure state");
	a_fail_no_route: assert property ( // [R23]
		@(posedge clock) disable iff (!rst_b)
		fail_led |-> ##1 (vid_route == '0 && emu_valid == '0))
		else $error("data passes while failed");
	a_fail_no_accept: assert property ( // [R23]
		@(posedge clock) disable iff (!rst_b)
		fail_led |-> !km_ready)
		else $error("keyboard word accepted while failed");
	a_bad_src_ignored: assert property ( // [R15]
		@(posedge clock) disable iff (!rst_b)
		(sw_req && !src_user && sel_valid) |=> $stable(sel_host))
		else $error("switched from a forbidden source");
	a_user_switch: assert property ( // [R16]
		@(posedge clock) disable iff (!rst_b)
		sw_take |=> (sel_host == $past(sw_host) && sel_valid))
		else $error("user switch not taken");
	a_tied_route: assert property ( // [R17]
		@(posedge clock) disable iff (!rst_b)
		(|emu_valid) |-> (emu_valid & ~(1 << sel_host)) == '0)
		else $error("keyboard off the selected host");
	a_purge_buffer: assert property ( // [R18]
		@(posedge clock) disable iff (!rst_b)
		sw_chg |=> (!buf_valid && emu_valid == '0 && emu_data == '0))
		else $error("keyboard data survived a switch");
	a_edid_once: assert property ( // [R3]
		@(posedge clock) disable iff (!rst_b)
		edid_fetch |=> !edid_fetch [*8])
		else $error("identification fetched twice");
	a_reject_flag: assert property ( // [R4]
		@(posedge clock) disable iff (!rst_b)
		(per_enum && !per_good) |=> (reject_led && !admit_r))
		else $error("bad peripheral not rejected");
	a_no_sel_pretest: assert property ( // [R24]
		@(posedge clock) disable iff (!rst_b)
		st_r == pspc_pkg::pspc_st_test |-> !sel_valid)
		else $error("host selected before self-test");
	a_sub_blocked: assert property ( // [R6] [R8]
		@(posedge clock) disable iff (!rst_b)
		sub_pass[pspc_pkg::SUB_HEC:pspc_pkg::SUB_CEC] == '0)
		else $error("blocked sub-protocol open");
	a_dp_link_pass: assert property ( // [R7]
		@(posedge clock) disable iff (!rst_b)
		(running && !vid_is_hdmi) |=> sub_pass[pspc_pkg::SUB_LINKTRN])
		else $error("link training blocked on DisplayPort");
	a_hdmi_no_train: assert property ( // [R8]
		@(posedge clock) disable iff (!rst_b)
		vid_is_hdmi |=> !sub_pass[pspc_pkg::SUB_LINKTRN])
		else $error("link training open on HDMI");
	a_tamper_kept: assert property ( // [R19]
		@(posedge clock) disable iff (!rst_b)
		tamper_in |=> tamper_seen [*8])
		else $error("tamper flag lost");

endmodule // pspc_ctrl

/* File: dv/pspc_host_model.sv */
// Model of the hosts and the display that face the switch
`timescale 1ns/10ps
module pspc_host_model #(
	parameter int NUM_HOSTS = 4
) (
	// Clock and reset
	input  wire logic                                clock,
	input  wire logic                                rst_b,
	// Emulated words toward the hosts
	input  wire logic [NUM_HOSTS-1:0]                emu_valid,
	output logic      [NUM_HOSTS-1:0]                emu_ready,
	input  wire logic [pspc_pkg::KM_DATA_W-1:0]      emu_data,
	input  wire logic                                stall,
	// Display identification fetch
	input  wire logic                                edid_fetch,
	output logic                                     edid_done,
	// Observations for the bench
	output logic      [7:0]                          rx_cnt,
	output logic      [pspc_pkg::KM_DATA_W-1:0]      rx_data,
	output logic      [1:0]                          rx_host,
	output logic      [7:0]                          fetch_cnt
);
	logic [2:0] dly_r;

	// All hosts stall together, which keeps words piling up in the buffer
	assign emu_ready = stall ? '0 : '1;

	// Take words, count fetches, answer a fetch three cycles later
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dly_r     <= 3'h0;
			edid_done <= 1'b0;
			fetch_cnt <= 8'h00;
			rx_cnt    <= 8'h00;
			rx_data   <= '0;
			rx_host   <= 2'h0;
		end else begin
			edid_done <= (dly_r == 3'h1);
			if (edid_fetch) begin
				fetch_cnt <= fetch_cnt + 8'h01;
				dly_r     <= 3'h3;
			end else if (dly_r != 3'h0) begin
				dly_r <= dly_r - 3'h1;
			end
			for (int h = 0; h < NUM_HOSTS; h++) begin
				if (emu_valid[h] && emu_ready[h]) begin
					rx_cnt  <= rx_cnt + 8'h01;
					rx_data <= emu_data;
					rx_host <= h[1:0];
				end
			end
		end
	end
endmodule // pspc_host_model

/* File: dv/pspc_ctrl_tb.sv */
// Self-checking testbench of the policy and switching control
`timescale 1ns/10ps
module pspc_ctrl_tb;
	localparam int ST = 8;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic        ctl_test_ok = 1'b1;
	logic        sw_req = 1'b0;
	logic [2:0]  sw_src = 3'h0;
	logic [1:0]  sw_host = 2'h0;
	logic        per_enum = 1'b0;
	logic [15:0] per_id = 16'h1234;
	logic        per_proto_ok = 1'b1;
	logic        per_id_allowed = 1'b1;
	logic        km_valid = 1'b0;
	logic        km_ready;
	logic [7:0]  km_data = 8'h00;
	logic [3:0]  emu_valid;
	logic [3:0]  emu_ready;
	logic [7:0]  emu_data;
	logic        edid_fetch;
	logic        edid_done;
	logic        vid_is_hdmi = 1'b0;
	logic [3:0]  vid_route;
	logic [9:0]  sub_pass;
	logic        tamper_in = 1'b0;
	logic        tamper_seen;
	logic [1:0]  sel_host;
	logic        sel_valid;
	logic        reject_led;
	logic        fail_led;
	logic        fail_tone;
	logic        stall = 1'b0;
	logic [7:0]  rx_cnt;
	logic [7:0]  rx_data;
	logic [1:0]  rx_host;
	logic [7:0]  fetch_cnt;
	int          fails = 0;
	int          n_compared = 0;

	// Clock of 50 MHz
	always #10 clock = ~clock;

	pspc_ctrl #(.NUM_HOSTS(4), .SELFTEST_CYC(ST)) DUT (
		.clock(clock), .rst_b(rst_b), .ctl_test_ok(ctl_test_ok),
		.sw_req(sw_req), .sw_src(sw_src), .sw_host(sw_host),
		.per_enum(per_enum), .per_id(per_id), .per_proto_ok(per_proto_ok),
		.per_id_allowed(per_id_allowed), .km_valid(km_valid),
		.km_ready(km_ready), .km_data(km_data), .emu_valid(emu_valid),
		.emu_ready(emu_ready), .emu_data(emu_data),
		.edid_fetch(edid_fetch), .edid_done(edid_done),
		.vid_is_hdmi(vid_is_hdmi), .vid_route(vid_route),
		.sub_pass(sub_pass), .tamper_in(tamper_in),
		.tamper_seen(tamper_seen), .sel_host(sel_host),
		.sel_valid(sel_valid), .reject_led(reject_led),
		.fail_led(fail_led), .fail_tone(fail_tone));

	pspc_host_model #(.NUM_HOSTS(4)) u_far (
		.clock(clock), .rst_b(rst_b), .emu_valid(emu_valid),
		.emu_ready(emu_ready), .emu_data(emu_data), .stall(stall),
		.edid_fetch(edid_fetch), .edid_done(edid_done),
		.rx_cnt(rx_cnt), .rx_data(rx_data), .rx_host(rx_host),
		.fetch_cnt(fetch_cnt));

	// One compare for every kind of value, four-state exact
	task automatic chkv(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Reset held 6 cycles, released at a falling edge
	task automatic do_reset(input logic ok);
		ctl_test_ok = ok;
		rst_b = 1'b0;
		repeat (6) @(negedge clock);
		chkv("sel_valid in reset", 16'h0, {15'h0, sel_valid});
		rst_b = 1'b1;
	endtask

	task automatic switch_req(input logic [2:0] src, input logic [1:0] h);
		sw_req = 1'b1;
		sw_src = src;
		sw_host = h;
		@(negedge clock);
		sw_req = 1'b0;
		@(negedge clock);
	endtask

	task automatic enum_per(input logic proto, input logic allow);
		per_proto_ok = proto;
		per_id_allowed = allow;
		per_enum = 1'b1;
		@(negedge clock);
		per_enum = 1'b0;
		@(negedge clock);
	endtask

	// Offer one word; ready is settled just after the falling edge
	task automatic send(input logic [7:0] d, output bit ok);
		ok = 0;
		km_data = d;
		km_valid = 1'b1;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (km_ready === 1'b1)
				ok = 1;
			@(negedge clock);
		end
		km_valid = 1'b0;
		// Let an edge pass so a following offer never re-raises at once
		@(negedge clock);
	endtask

	task automatic wait_rx(input logic [7:0] n);
		for (int i = 0; i < 10 && rx_cnt !== n; i++)
			@(negedge clock);
	endtask

	task automatic t_boot();
		do_reset(1'b1);
		repeat (ST - 2) @(negedge clock);
		chkv("route during test", 16'h0, {12'h0, vid_route});
		for (int i = 0; i < 40 && fetch_cnt !== 8'h01; i++)
			@(negedge clock);
		repeat (20) @(negedge clock);
		chkv("fetch count", 16'h1, {8'h0, fetch_cnt});
		chkv("fail led", 16'h0, {15'h0, fail_led});
		$display("test boot done");
	endtask

	// Every source once: only button, remote and guard may switch
	task automatic t_switch();
		logic [1:0] exp_h;
		exp_h = 2'h0;
		for (int s = 0; s < 6; s++) begin
			switch_req(s[2:0], 2'(s + 1));
			if (s < 3)
				exp_h = 2'(s + 1);
			chkv("sel_host", {14'h0, exp_h}, {14'h0, sel_host});
			chkv("sel_valid", 16'h1, {15'h0, sel_valid});
			chkv("vid_route", 16'h1 << exp_h, {12'h0, vid_route});
		end
		$display("test switch done");
	endtask

	task automatic t_video();
		vid_is_hdmi = 1'b0;
		repeat (3) @(negedge clock);
		chkv("sub_pass dp", 16'h007, {6'h0, sub_pass});
		vid_is_hdmi = 1'b1;
		repeat (3) @(negedge clock);
		chkv("sub_pass hdmi", 16'h003, {6'h0, sub_pass});
		$display("test video done");
	endtask

	task automatic t_admit();
		bit ok;
		enum_per(1'b1, 1'b1);
		chkv("reject led", 16'h0, {15'h0, reject_led});
		send(8'hA5, ok);
		wait_rx(8'h01);
		chkv("rx data", 16'h00A5, {8'h0, rx_data});
		chkv("rx host", 16'h3, {14'h0, rx_host});
		enum_per(1'b1, 1'b0);
		chkv("reject led", 16'h1, {15'h0, reject_led});
		send(8'h5A, ok);
		chkv("refused word", 16'h0, {15'h0, ok});
		enum_per(1'b0, 1'b1);
		chkv("reject proto", 16'h1, {15'h0, reject_led});
		enum_per(1'b1, 1'b1);
		$display("test admit done");
	endtask

	// Fill the buffer while hosts stall, then switch and expect a purge
	task automatic t_flush();
		bit ok;
		int n;
		n = 0;
		stall = 1'b1;
		ok = 1;
		for (int i = 0; i < 6 && ok; i++) begin
			send(8'(8'h10 + i), ok);
			n += int'(ok);
		end
		chkv("buffer depth", 16'h3, 16'(n));
		chkv("emu_valid", 16'h8, {12'h0, emu_valid});
		chkv("emu_data", 16'h0010, {8'h0, emu_data});
		switch_req(3'h0, 2'h0);
		chkv("emu_valid purge", 16'h0, {12'h0, emu_valid});
		chkv("emu_data purge", 16'h0, {8'h0, emu_data});
		stall = 1'b0;
		repeat (6) @(negedge clock);
		chkv("rx after purge", 16'h1, {8'h0, rx_cnt});
		send(8'h77, ok);
		wait_rx(8'h02);
		chkv("rx new host", 16'h0, {14'h0, rx_host});
		chkv("rx new data", 16'h0077, {8'h0, rx_data});
		$display("test flush done");
	endtask

	task automatic t_tamper();
		chkv("tamper clear", 16'h0, {15'h0, tamper_seen});
		tamper_in = 1'b1;
		@(negedge clock);
		tamper_in = 1'b0;
		repeat (20) @(negedge clock);
		chkv("tamper held", 16'h1, {15'h0, tamper_seen});
		$display("test tamper done");
	endtask

	// Failed self-test: secure state, warnings, nothing passes
	task automatic t_fail();
		do_reset(1'b0);
		repeat (ST + 4) @(negedge clock);
		chkv("fail led", 16'h1, {15'h0, fail_led});
		switch_req(3'h0, 2'h1);
		chkv("sel_valid fail", 16'h0, {15'h0, sel_valid});
		chkv("route fail", 16'h0, {12'h0, vid_route});
		chkv("sub_pass fail", 16'h0, {6'h0, sub_pass});
		chkv("km_ready fail", 16'h0, {15'h0, km_ready});
		chkv("no fetch", 16'h0, {8'h0, fetch_cnt});
		for (int i = 0; i < pspc_pkg::TONE_HALF_CYC + 40 && !fail_tone; i++)
			@(negedge clock);
		chkv("fail tone", 16'h1, {15'h0, fail_tone});
		chkv("fail held", 16'h1, {15'h0, fail_led});
		$display("test fail done");
	endtask

	// Main sequence
	initial begin
		t_boot();
		t_switch();
		t_video();
		t_admit();
		t_flush();
		t_tamper();
		t_fail();
		conclude();
	end

	// Watchdog: the tests need about 13000 cycles
	initial begin
		repeat (60000) @(posedge clock);
		fails++;
		conclude();
	end
endmodule // pspc_ctrl_tb
